// >>> rtl/port_pin_mode_regs.svh
`ifndef PORT_PIN_MODE_REGS_SVH
`define PORT_PIN_MODE_REGS_SVH
// Register indices; byte address is four times the index
`define PORT3_LOW_MODE_IDX 8'heb
`define GROUP0_NIBBLE_MODE_IDX 8'hed
`define GROUP1_NIBBLE_MODE_IDX 8'hee
`define GROUP2_NIBBLE_MODE_IDX 8'hef
`define PORT3_PIN_PULLUPS_IDX 8'hec
`define PORT3_LOW_MODE_RST 8'h00
`define GROUP0_NIBBLE_MODE_RST 8'h00
`define GROUP1_NIBBLE_MODE_RST 8'h00
`define GROUP2_NIBBLE_MODE_RST 8'h00
`define PORT3_PIN_PULLUPS_RST 8'h00
`define NIBBLE_LOW_A_POS 6
`define NIBBLE_HIGH_A_POS 4
`define NIBBLE_LOW_B_POS 2
`define NIBBLE_HIGH_B_POS 0
`define SCK_FIELD_POS 2
`define SO_FIELD_POS 4
`define SI_FIELD_POS 6
`define BUZ_FIELD_POS 0
`endif

// >>> rtl/port_pin_mode_pkg.sv
package port_pin_mode_pkg;
	typedef enum logic [1:0] {
		P3_INPUT = 2'h0,
		P3_OPEN_DRAIN = 2'h1,
		P3_ALTERNATE = 2'h2,
		P3_PUSH_PULL = 2'h3
	} p3_mode_t;
	typedef enum logic [1:0] {
		NIB_INPUT = 2'h0,
		NIB_INPUT_PULLUP = 2'h1,
		NIB_OPEN_DRAIN = 2'h2,
		NIB_PUSH_PULL = 2'h3
	} nib_mode_t;
	typedef enum {
		BUS_IDLE,
		BUS_ACK
	} bus_state_t;
endpackage

// >>> rtl/port_pin_mode_config.sv
// Overview of operation
// - Port3 low mode: four 2-bit fields, reset input
// - Registers reachable only by direct register access
// - Clock pin: code 10 drives serial clock out
// - Eight pull-up enable bits, reset zero
// - Group0 nibble modes: input, pullup, OD, PP
// - Group0 bits 7:6 first port low nibble
// - Group0 bits 5:4 first port high nibble
// - Group0 bits 3:2 second port low nibble
// - Group0 bits 1:0 second port high nibble
// - Group1 same encodings, third and fourth ports
// - Group1 bits 7:6 third port low nibble
// - Group1 bits 5:4 third port high nibble
// - Group1 bits 3:2 fourth port low nibble
// - Group1 bits 1:0 fourth port high nibble
// - Group2 register read-write, resets zero
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "port_pin_mode_regs.svh"
module port_pin_mode_config
	import port_pin_mode_pkg::*;
(
	input wire logic core_clk, // System clock
	input wire logic rst_b, // Async reset, active low
	input wire logic wb_cyc_i, // Wishbone cycle
	input wire logic wb_stb_i, // Wishbone strobe
	input wire logic wb_we_i, // Wishbone write
	input wire logic [9:0] wb_adr_i, // Byte address
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic [31:0] wb_dat_i, // Write data
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	output logic wb_err_o, // Unmapped address
	input wire logic [3:0] port3Pin, // Port3 pins 0..3 from pads
	output logic [3:0] port3Out, // Port3 pad output value
	output logic [3:0] port3Oe, // Port3 pad output enable
	output logic [7:0] port3PullEn, // Port3 pull-up enables
	input wire logic [3:0] port3Data, // Port3 data latch bits 0..3
	input wire logic serial_zero_output, // Serial data from serial unit
	input wire logic serial_zero_clock, // Serial clock from serial unit
	input wire logic buzzer_output, // Buzzer waveform
	output logic serial_zero_input, // Synchronised serial data in
	output logic serialClkIn, // Synchronised serial clock in
	input wire logic [31:0] lcdPin, // Ports 4..7 pins from pads
	input wire logic [31:0] lcdData, // Ports 4..7 data latches
	output logic [31:0] lcdOut, // Ports 4..7 pad output value
	output logic [31:0] lcdOe, // Ports 4..7 pad output enable
	output logic [31:0] lcdPullEn, // Ports 4..7 pull-up enables
	output logic [31:0] lcdIn // Synchronised ports 4..7 inputs
);
	logic [7:0] port3ModeFf;
	logic [7:0] group0Ff;
	logic [7:0] group1Ff;
	logic [7:0] group2Ff;
	logic [7:0] pullupsFf;
	logic ackFf;
	logic errFf;
	logic [31:0] rdataFf;
	logic [3:0] p3SyncA;
	logic [3:0] p3SyncB;
	logic [3:0] p3SyncC;
	logic [3:0] p3StableFf;
	logic [31:0] lcdSyncA;
	logic [31:0] lcdSyncB;
	logic [31:0] lcdSyncC;
	logic [31:0] lcdStableFf;
	logic [3:0] port3OutFf;
	logic [3:0] port3OeFf;
	logic [31:0] lcdOutFf;
	logic [31:0] lcdOeFf;
	logic [31:0] lcdPullFf;
	logic [7:0] p3PullFf;
	logic serialClkFf;

	// Word index from byte address
	wire [7:0] regIdx = wb_adr_i[9:2];
	wire busReq = wb_cyc_i & wb_stb_i & ~ackFf & ~errFf;
	wire hitP3 = regIdx == `PORT3_LOW_MODE_IDX;
	wire hitG0 = regIdx == `GROUP0_NIBBLE_MODE_IDX;
	wire hitG1 = regIdx == `GROUP1_NIBBLE_MODE_IDX;
	wire hitG2 = regIdx == `GROUP2_NIBBLE_MODE_IDX;
	wire hitPu = regIdx == `PORT3_PIN_PULLUPS_IDX;
	wire hitAny = hitP3 | hitG0 | hitG1 | hitG2 | hitPu;
	// Only the low lane carries data; a write without it is a no-op
	wire wrLane = busReq & wb_we_i & hitAny & wb_sel_i[0];
	wire [7:0] wrByte = wb_dat_i[7:0];
	wire [7:0] rdSel = hitP3 ? port3ModeFf : hitG0 ? group0Ff : hitG1 ? group1Ff :
		hitG2 ? group2Ff : hitPu ? pullupsFf : 8'h00;

	// Direct access only, each register one word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			port3ModeFf <= `PORT3_LOW_MODE_RST;
		else if (wrLane && hitP3)
			port3ModeFf <= wrByte;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			group0Ff <= `GROUP0_NIBBLE_MODE_RST;
		else if (wrLane && hitG0)
			group0Ff <= wrByte;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			group1Ff <= `GROUP1_NIBBLE_MODE_RST;
		else if (wrLane && hitG1)
			group1Ff <= wrByte;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			group2Ff <= `GROUP2_NIBBLE_MODE_RST;
		else if (wrLane && hitG2)
			group2Ff <= wrByte;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pullupsFf <= `PORT3_PIN_PULLUPS_RST;
		else if (wrLane && hitPu)
			pullupsFf <= wrByte;
	end

	// Pending ack or err keeps one request from being taken twice
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ackFf <= 1'b0;
			errFf <= 1'b0;
		end else begin
			ackFf <= busReq & hitAny;
			errFf <= busReq & ~hitAny;
		end
	end

	// Refreshed every cycle; only meaningful beside ack
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			rdataFf <= 32'h0;
		else
			rdataFf <= {24'h0, rdSel};
	end

	assign wb_ack_o = ackFf;
	assign wb_err_o = errFf;
	assign wb_dat_o = rdataFf;

	// Follows stages 2 and 3 once they agree, otherwise holds
	function automatic logic [31:0] agreeFilter(input logic [31:0] held, input logic [31:0] mid,
		input logic [31:0] last);
		agreeFilter = (mid & last) | (held & (mid | last));
	endfunction

	// Three-stage input sync; change accepted when stages 2 and 3 agree
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			p3SyncA <= 4'h0;
			p3SyncB <= 4'h0;
			p3SyncC <= 4'h0;
			p3StableFf <= 4'h0;
		end else begin
			p3SyncA <= port3Pin;
			p3SyncB <= p3SyncA;
			p3SyncC <= p3SyncB;
			p3StableFf <= 4'(agreeFilter(32'(p3StableFf), 32'(p3SyncB), 32'(p3SyncC)));
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lcdSyncA <= 32'h0;
			lcdSyncB <= 32'h0;
			lcdSyncC <= 32'h0;
			lcdStableFf <= 32'h0;
		end else begin
			lcdSyncA <= lcdPin;
			lcdSyncB <= lcdSyncA;
			lcdSyncC <= lcdSyncB;
			lcdStableFf <= agreeFilter(lcdStableFf, lcdSyncB, lcdSyncC);
		end
	end

	assign serial_zero_input = p3StableFf[3];
	// Clock input only in input mode; the output flop costs one cycle of latency
	wire nxt_serialClk = (port3ModeFf[`SCK_FIELD_POS +: 2] == P3_INPUT) ? p3StableFf[1] : 1'b0;
	assign serialClkIn = serialClkFf;
	assign lcdIn = lcdStableFf;

	// Per-pin alternate source; SI0 pin has none, its 10 code is reserved
	wire [3:0] altSrc = {1'b0, serial_zero_output, serial_zero_clock, buzzer_output};
	wire [3:0] altValid = 4'h7;
	logic [3:0] nxt_port3Out;
	logic [3:0] nxt_port3Oe;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_p3
			wire [1:0] code = port3ModeFf[2*gi +: 2];
			always_comb begin
				case (p3_mode_t'(code))
					P3_INPUT: begin
						nxt_port3Out[gi] = 1'b0;
						nxt_port3Oe[gi] = 1'b0;
					end
					P3_OPEN_DRAIN: begin
						nxt_port3Out[gi] = 1'b0;
						nxt_port3Oe[gi] = ~port3Data[gi];
					end
					P3_ALTERNATE: begin
						nxt_port3Out[gi] = altSrc[gi] & altValid[gi];
						nxt_port3Oe[gi] = altValid[gi];
					end
					P3_PUSH_PULL: begin
						nxt_port3Out[gi] = port3Data[gi];
						nxt_port3Oe[gi] = 1'b1;
					end
					default: begin
						nxt_port3Out[gi] = 1'b0;
						nxt_port3Oe[gi] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	// Nibble field per group of four pins, low nibble first
	function automatic logic [1:0] nibField(input logic [7:0] g0, input logic [7:0] g1, input int n);
		logic [7:0] grp;
		grp = (n < 4) ? g0 : g1;
		case (n % 4)
			0: nibField = grp[`NIBBLE_LOW_A_POS +: 2];
			1: nibField = grp[`NIBBLE_HIGH_A_POS +: 2];
			2: nibField = grp[`NIBBLE_LOW_B_POS +: 2];
			default: nibField = grp[`NIBBLE_HIGH_B_POS +: 2];
		endcase
	endfunction

	logic [31:0] nxt_lcdOut;
	logic [31:0] nxt_lcdOe;
	logic [31:0] nxt_lcdPull;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_lcd
			wire [1:0] code = nibField(group0Ff, group1Ff, gi / 4);
			always_comb begin
				case (nib_mode_t'(code))
					NIB_INPUT: begin
						nxt_lcdOut[gi] = 1'b0;
						nxt_lcdOe[gi] = 1'b0;
						nxt_lcdPull[gi] = 1'b0;
					end
					NIB_INPUT_PULLUP: begin
						nxt_lcdOut[gi] = 1'b0;
						nxt_lcdOe[gi] = 1'b0;
						nxt_lcdPull[gi] = 1'b1;
					end
					NIB_OPEN_DRAIN: begin
						nxt_lcdOut[gi] = 1'b0;
						nxt_lcdOe[gi] = ~lcdData[gi];
						nxt_lcdPull[gi] = 1'b0;
					end
					NIB_PUSH_PULL: begin
						nxt_lcdOut[gi] = lcdData[gi];
						nxt_lcdOe[gi] = 1'b1;
						nxt_lcdPull[gi] = 1'b0;
					end
					default: begin
						nxt_lcdOut[gi] = 1'b0;
						nxt_lcdOe[gi] = 1'b0;
						nxt_lcdPull[gi] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	// Registered drivers: write at edge N shows on pins after edge N+1
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			port3OutFf <= 4'h0;
			port3OeFf <= 4'h0;
			p3PullFf <= 8'h0;
			serialClkFf <= 1'b0;
		end else begin
			port3OutFf <= nxt_port3Out;
			port3OeFf <= nxt_port3Oe;
			p3PullFf <= pullupsFf;
			serialClkFf <= nxt_serialClk;
		end
	end

	// Pull-up and drive come from one decoded code, so they never overlap
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lcdOutFf <= 32'h0;
			lcdOeFf <= 32'h0;
			lcdPullFf <= 32'h0;
		end else begin
			lcdOutFf <= nxt_lcdOut;
			lcdOeFf <= nxt_lcdOe;
			lcdPullFf <= nxt_lcdPull;
		end
	end

	assign port3Out = port3OutFf;
	assign port3Oe = port3OeFf;
	assign port3PullEn = p3PullFf;
	assign lcdOut = lcdOutFf;
	assign lcdOe = lcdOeFf;
	assign lcdPullEn = lcdPullFf;
endmodule

// >>> bench/port_pin_mode_config_properties.sv
`timescale 1ns/10ps
module port_pin_mode_config_properties (
	input wire logic core_clk, // Clock
	input wire logic rst_b, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [9:0] wb_adr_i, // Address
	input wire logic [3:0] wb_sel_i, // Lanes
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire logic wb_err_o, // Error
	input wire logic [7:0] port3PullEn, // Pull-ups
	input wire logic [31:0] lcdOe, // Enables
	input wire logic [31:0] lcdPullEn // Pull-ups
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire [7:0] idx = wb_adr_i[9:2];
	wire mapped = idx inside {8'heb, 8'hec, 8'hed, 8'hee, 8'hef};
	wire pullWr = wb_ack_o && wb_we_i && idx == 8'hec;
	AST_MAPPED_ACK: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
		else $error("no ack for mapped access");
	AST_UNMAPPED_ERR: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
		else $error("no error for unmapped access");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ERR_PULSE: assert property (wb_err_o |=> !wb_err_o)
		else $error("err longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_RD_UPPER: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
		else $error("read data upper bits set");
	AST_PULL_WRITE: assert property (pullWr && wb_sel_i[0] |=> port3PullEn == $past(wb_dat_i[7:0]))
		else $error("pull-up write not applied");
	AST_PULL_HOLD: assert property (!pullWr |=> $stable(port3PullEn))
		else $error("pull-ups changed without write");
	AST_NIB_PULL: assert property (lcdPullEn == {{4{lcdPullEn[28]}}, {4{lcdPullEn[24]}}, {4{lcdPullEn[20]}},
		{4{lcdPullEn[16]}}, {4{lcdPullEn[12]}}, {4{lcdPullEn[8]}}, {4{lcdPullEn[4]}}, {4{lcdPullEn[0]}}})
		else $error("nibble pull-ups not uniform");
	AST_PULL_NOT_OE: assert property ((lcdPullEn & lcdOe) == 32'h0)
		else $error("pull-up on a driven pin");
	cover property (wb_err_o);
	cover property (wb_ack_o && wb_we_i);
	cover property (lcdPullEn != 32'h0);
endmodule
bind port_pin_mode_config port_pin_mode_config_properties chk (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port3PullEn, .lcdOe, .lcdPullEn);

// >>> bench/port_pin_mode_config_tb.sv
`timescale 1ns/10ps
module port_pin_mode_config_tb import port_pin_mode_pkg::*;;
	logic core_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [9:0] wb_adr_i = 10'h0;
	logic [3:0] wb_sel_i = 4'h0, port3Pin = 4'ha, port3Data = 4'h6;
	logic [31:0] wb_dat_i = 32'h0, lcdPin = 32'h3cc3_a55a, lcdData = 32'h5a3c_96f0;
	logic serial_zero_output = 1'b1, serial_zero_clock = 1'b0, buzzer_output = 1'b1;
	logic [31:0] wb_dat_o, lcdOut, lcdOe, lcdPullEn, lcdIn, rd;
	logic wb_ack_o, wb_err_o, serial_zero_input, serialClkIn, er;
	logic [3:0] port3Out, port3Oe;
	logic [7:0] port3PullEn;
	logic [9:0] regs [5] = '{10'h3ac, 10'h3b0, 10'h3b4, 10'h3b8, 10'h3bc};
	int fails = 0, n_tests = 0, cycles = 0;
	port_pin_mode_config dut (.core_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port3Pin, .port3Out, .port3Oe, .port3PullEn, .port3Data,
		.serial_zero_output, .serial_zero_clock, .buzzer_output, .serial_zero_input, .serialClkIn,
		.lcdPin, .lcdData, .lcdOut, .lcdOe, .lcdPullEn, .lcdIn);
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	task test_done;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			test_done();
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// Holds the request until ack or err is sampled, never assumes a latency
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		wb_sel_i <= s;
		do @(posedge core_clk); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task t_regs;
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, regs[i], 8'h0, 4'hf);
			chk(rd[7:0], 8'h00);
			chk({7'h0, er}, 8'h00);
			bus(1'b1, regs[i], 8'ha5 + 8'(i), 4'h1);
			bus(1'b1, regs[i], 8'h3c, 4'he);
			bus(1'b0, regs[i], 8'h0, 4'hf);
			chk(rd[7:0], 8'ha5 + 8'(i));
			bus(1'b1, regs[i], 8'h00, 4'h1);
		end
		bus(1'b1, 10'h000, 8'hff, 4'h1);
		chk({7'h0, er}, 8'h01);
		bus(1'b0, 10'h3c0, 8'h0, 4'hf);
		chk({7'h0, er}, 8'h01);
	endtask
	task t_port3(input logic [7:0] mode, input logic [7:0] exp);
		bus(1'b1, 10'h3ac, mode, 4'h1);
		@(negedge core_clk);
		chk({port3Oe, port3Out[2:0], serialClkIn}, exp);
	endtask
	task t_alt;
		bus(1'b1, 10'h3ac, 8'haa, 4'h1);
		serial_zero_output <= 1'b0;
		serial_zero_clock <= 1'b1;
		buzzer_output <= 1'b0;
		@(posedge core_clk);
		@(negedge core_clk);
		chk({port3Oe, port3Out}, 8'h72);
		@(posedge core_clk);
		port3Data <= 4'h9;
		bus(1'b1, 10'h3ac, 8'hff, 4'h1);
		@(negedge core_clk);
		chk({port3Oe, port3Out}, 8'hf9);
	endtask
	task t_sync;
		chk({7'h0, serial_zero_input}, 8'h01);
		for (int i = 0; i < 4; i++)
			chk(lcdIn[8 * i +: 8], lcdPin[8 * i +: 8]);
		@(posedge core_clk);
		port3Pin <= 4'h2;
		lcdPin <= ~lcdPin;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk({7'h0, serial_zero_input}, 8'h01);
		chk(lcdIn[7:0], ~lcdPin[7:0]);
		@(negedge core_clk);
		chk({7'h0, serial_zero_input}, 8'h00);
		chk(lcdIn[7:0], lcdPin[7:0]);
	endtask
	task t_pull;
		bus(1'b1, 10'h3b0, 8'h5a, 4'h1);
		@(negedge core_clk);
		chk(port3PullEn, 8'h5a);
	endtask
	task t_reset;
		@(posedge core_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk(port3PullEn, 8'h00);
		chk({port3Oe, port3Out}, 8'h00);
		chk(lcdOe[7:0], 8'h00);
		@(posedge core_clk);
		rst_b <= 1'b1;
		bus(1'b0, 10'h3ac, 8'h0, 4'hf);
		chk(rd[7:0], 8'h00);
		bus(1'b0, 10'h3b4, 8'h0, 4'hf);
		chk(rd[7:0], 8'h00);
	endtask
	task t_lcd;
		logic [7:0] g;
		logic [1:0] m;
		logic [3:0] d, oe;
		for (int r = 0; r < 2; r++) begin
			g = r ? 8'he4 : 8'h1b;
			bus(1'b1, 10'h3b4, g, 4'h1);
			bus(1'b1, 10'h3b8, ~g, 4'h1);
			@(negedge core_clk);
			for (int n = 0; n < 8; n++) begin
				m = 2'(((n < 4) ? g : ~g) >> (6 - 2 * (n % 4)));
				d = lcdData[4 * n +: 4];
				oe = (m == 2'h3) ? 4'hf : (m == 2'h2) ? ~d : 4'h0;
				chk({lcdOe[4 * n +: 4], lcdPullEn[4 * n +: 4]}, {oe, {4{m == 2'h1}}});
				if (m[1])
					chk({4'h0, lcdOut[4 * n +: 4]}, {4'h0, m[0] ? d : 4'h0});
			end
		end
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		t_regs();
		t_port3(8'hff, 8'hfc);
		t_port3(8'h55, 8'h90);
		t_port3(8'haa, 8'h7a);
		t_port3(8'h00, 8'h01);
		t_sync();
		t_alt();
		t_pull();
		t_lcd();
		t_reset();
		test_done();
	end
endmodule
